// ==== fpia_top.sv ====
// module: flash pin irq aggregator with ahb-lite register slave
//
// Behaviour
// - 24 irq bits per word; bits 31:24 read zero and ignore writes.
// - four bits per pin: level low, level high, fall, rise; sclk, ss, d0..d3.
// - transition flags latch on their edge; writing one to the bit clears it.
// - level flags are read-only and follow the present pin condition.
// - first core enable mask: 24 bits, read/write, resets to zero.
// - first core force word: 24 bits, read/write, reset zero, forces status.
// - masked status is raw and enable, or force; read-only.
// - raw flags take the pin condition after its override select.
//
// The AHB-Lite register port was decided locally.
module fpia_top
  import fpia_pkg::*;
#(
  parameter int NUM_PINS = FPIA_NUM_PINS
)
(
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic [1:0]                  hresp,
  // flash interface pins: sclk, ss, data_line_0 .. data_line_3
  input  wire logic [NUM_PINS-1:0]    pin_level,
  // interrupt to the first core
  output logic                        irq_first_core
);

  localparam int IRQ_BITS = NUM_PINS * FPIA_BITS_PER_PIN;
  localparam int OVR_BITS = NUM_PINS * 2;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [IRQ_BITS-1:0] en_q;
  logic [IRQ_BITS-1:0] force_q;
  logic [OVR_BITS-1:0] ovr_q;
  logic [31:0]         hrdata_q;
  logic                hready_q;
  logic                irq_q;
  logic                wr_pend_q;
  logic                rd_pend_q;
  logic [7:0]          addr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // per-pin conditions
  fpia_pin_flags_t [NUM_PINS-1:0] pin_flags;
  fpia_pin_clr_t   [NUM_PINS-1:0] pin_clr;
  logic [NUM_PINS-1:0]            post_ovr;
  logic [IRQ_BITS-1:0]            raw_flags;
  logic [IRQ_BITS-1:0]            raw_clr;
  logic [IRQ_BITS-1:0]            masked;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic        addr_phase;
  logic        rd_req;
  logic        wr_req;
  logic        wr_raw;
  logic        wr_en;
  logic        wr_force;
  logic        wr_ovr;
  logic [31:0] rd_mux;
  logic [31:0] wdata_word;

  // a transfer is taken only on a nonseq with the bus ready, whatever its hsize
  assign addr_phase = hsel & hready & (htrans == FPIA_HTRANS_NONSEQ);
  assign rd_req     = addr_phase & ~hwrite;
  assign wr_req     = addr_phase & hwrite;

  // writes take effect at the end of their data phase
  assign wdata_word = hwdata;
  assign wr_raw     = wr_pend_q & (addr_q == FPIA_RAW_OFS);
  assign wr_en      = wr_pend_q & (addr_q == FPIA_EN_OFS);
  assign wr_force   = wr_pend_q & (addr_q == FPIA_FORCE_OFS);
  assign wr_ovr     = wr_pend_q & (addr_q == FPIA_OVR_OFS);

  ////////////////////////////////////////////////////////////////////////////////
  // pin instances, one group of four raw bits each
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      fpia_pin_cond u_pin (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .pin_level           (pin_level[gi]),
        .irq_override_select (fpia_ovr_t'(ovr_q[2*gi +: 2])),
        .clr                 (pin_clr[gi]),
        .flags               (pin_flags[gi]),
        .post_override_irq   (post_ovr[gi])
      );

      // write-one-to-clear, transition bits only
      assign pin_clr[gi].fall = raw_clr[FPIA_BITS_PER_PIN*gi + FPIA_FALL_BIT];
      assign pin_clr[gi].rise = raw_clr[FPIA_BITS_PER_PIN*gi + FPIA_RISE_BIT];

      // pins stack upward from sclk at bits 3:0
      assign raw_flags[FPIA_BITS_PER_PIN*gi +: FPIA_BITS_PER_PIN] = pin_flags[gi];
    end
  endgenerate

  // level bits get no clear path, so writes to them do nothing
  assign raw_clr = wr_raw ? wdata_word[IRQ_BITS-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // masking and forcing for the first core
  assign masked = (raw_flags & en_q) | force_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read data; unmapped and reserved bits read zero
  assign rd_mux =
    (addr_q == FPIA_RAW_OFS)    ? {{(32-IRQ_BITS){1'b0}}, raw_flags} :
    (addr_q == FPIA_EN_OFS)     ? {{(32-IRQ_BITS){1'b0}}, en_q}      :
    (addr_q == FPIA_FORCE_OFS)  ? {{(32-IRQ_BITS){1'b0}}, force_q}   :
    (addr_q == FPIA_STATUS_OFS) ? {{(32-IRQ_BITS){1'b0}}, masked}    :
    (addr_q == FPIA_OVR_OFS)    ? {{(32-OVR_BITS){1'b0}}, ovr_q}     :
    (addr_q == FPIA_LEVEL_OFS)  ? {{(32-FPIA_LEVEL_POST_LSB-NUM_PINS){1'b0}}, post_ovr,
                                   {(FPIA_LEVEL_POST_LSB-NUM_PINS){1'b0}}, pin_level} :
                                  32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // bus phase tracking
  // reads take one wait state so the data phase sees any write just before it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q    <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hready_q  <= 1'b1;
    end else begin
      if (addr_phase) begin
        addr_q <= {haddr[7:2], 2'h0};
      end
      wr_pend_q <= wr_req;
      rd_pend_q <= rd_req;
      hready_q  <= ~rd_req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= FPIA_EN_RST;
    end else if (wr_en) begin
      en_q <= wdata_word[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_q <= FPIA_FORCE_RST;
    end else if (wr_force) begin
      force_q <= wdata_word[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_q <= FPIA_OVR_RST;
    end else if (wr_ovr) begin
      ovr_q <= wdata_word[OVR_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt to the core, registered so it is glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |masked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout      = hready_q;
  assign hrdata         = hrdata_q;
  assign hresp          = FPIA_HRESP_OKAY;
  assign irq_first_core = irq_q;

endmodule

// ==== fpia_pkg.sv ====
// package: register map, field layout and shared types of the flash pin irq aggregator
package fpia_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int FPIA_NUM_PINS      = 6;
  localparam int FPIA_BITS_PER_PIN  = 4;
  localparam int FPIA_IRQ_BITS      = 24;
  localparam int FPIA_OVR_BITS      = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] FPIA_RAW_OFS    = 8'h30;
  localparam logic [7:0] FPIA_EN_OFS     = 8'h34;
  localparam logic [7:0] FPIA_FORCE_OFS  = 8'h38;
  localparam logic [7:0] FPIA_STATUS_OFS = 8'h3c;
  localparam logic [7:0] FPIA_OVR_OFS    = 8'h58;
  localparam logic [7:0] FPIA_LEVEL_OFS  = 8'h5c;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions inside one pin's group of four
  localparam int FPIA_LVL_LOW_BIT  = 0;
  localparam int FPIA_LVL_HIGH_BIT = 1;
  localparam int FPIA_FALL_BIT     = 2;
  localparam int FPIA_RISE_BIT     = 3;

  // pin order inside the raw word
  localparam int FPIA_PIN_SCLK = 0;
  localparam int FPIA_PIN_SS   = 1;
  localparam int FPIA_PIN_D0   = 2;
  localparam int FPIA_PIN_D3   = 5;

  // level readback: post-override levels sit above the raw pins
  localparam int FPIA_LEVEL_POST_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [FPIA_IRQ_BITS-1:0] FPIA_EN_RST    = 24'h000000;
  localparam logic [FPIA_IRQ_BITS-1:0] FPIA_FORCE_RST = 24'h000000;
  localparam logic [FPIA_OVR_BITS-1:0] FPIA_OVR_RST   = 12'h000;

  // bus
  localparam logic [1:0] FPIA_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] FPIA_HRESP_OKAY    = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    FPIA_OVR_PASS,
    FPIA_OVR_INVERT,
    FPIA_OVR_LOW,
    FPIA_OVR_HIGH
  } fpia_ovr_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic lvl_high;
    logic lvl_low;
  } fpia_pin_flags_t;

  typedef struct packed {
    logic       fall;
    logic       rise;
  } fpia_pin_clr_t;

endpackage

// ==== fpia_pin_cond.sv ====
// module: one pin's override, level flags and latched transition flags
module fpia_pin_cond
  import fpia_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // pin side
  input  wire logic       pin_level,
  input  wire fpia_ovr_t  irq_override_select,
  // software clear of latched transitions, one-cycle pulses
  input  wire fpia_pin_clr_t clr,
  // results
  output fpia_pin_flags_t flags,
  output logic            post_override_irq
);

  logic       ovr_level;
  logic       lvl_q;
  logic       prev_q;
  logic [1:0] vld_q;
  logic       fall_q;
  logic       rise_q;
  logic       fall_set;
  logic       rise_set;

  always_comb begin
    case (irq_override_select)
      FPIA_OVR_PASS:   ovr_level = pin_level;
      FPIA_OVR_INVERT: ovr_level = ~pin_level;
      FPIA_OVR_LOW:    ovr_level = 1'b0;
      default:         ovr_level = 1'b1;
    endcase
  end

  // no edge is judged until both samples are real, so reset cannot fake one
  assign fall_set = vld_q[1] & prev_q & ~lvl_q;
  assign rise_set = vld_q[1] & ~prev_q & lvl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q  <= 1'b0;
      prev_q <= 1'b0;
      vld_q  <= 2'h0;
      fall_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      lvl_q  <= ovr_level;
      prev_q <= lvl_q;
      vld_q  <= {vld_q[0], 1'b1};
      // set wins over a clear in the same cycle
      fall_q <= fall_set | (fall_q & ~clr.fall);
      rise_q <= rise_set | (rise_q & ~clr.rise);
    end
  end

  assign flags.rise        = rise_q;
  assign flags.fall        = fall_q;
  assign flags.lvl_high    = vld_q[0] & lvl_q;
  assign flags.lvl_low     = vld_q[0] & ~lvl_q;
  assign post_override_irq = lvl_q;

endmodule

// ==== fpia_top_properties.sv ====
// checker: bus timing, readback and irq properties of the aggregator top
module fpia_top_properties
  import fpia_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [1:0]  hresp,
  // interrupt
  input wire logic        irq_first_core
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && (htrans == FPIA_HTRANS_NONSEQ);
  ////////////////////////////////////////////////////////////////////////////////
  rd_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read without one wait state");
  wr_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_once_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
    else $error("wait state without read");
  data_hold_a: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data moved outside a read");
  rsvd_zero_a: assert property (hrdata[31:24] == 8'h00)
    else $error("reserved bits read nonzero");
  resp_okay_a: assert property (hresp == FPIA_HRESP_OKAY)
    else $error("response not okay");
  irq_reset_a: assert property ($rose(hresetn) |-> !irq_first_core)
    else $error("irq high out of reset");
  ////////////////////////////////////////////////////////////////////////////////
  cover property (take && !hwrite);
  cover property (take && hwrite);
  cover property ($rose(irq_first_core));
endmodule

// ==== fpia_pin_model.sv ====
// model: flash pin levels as the far side presents them
module fpia_pin_model
  import fpia_pkg::*;
(
  input  wire logic                     hclk,
  input  wire logic [FPIA_NUM_PINS-1:0] pin_want,
  output logic      [FPIA_NUM_PINS-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move just after an edge, so sampling never races them
  initial pin_level = '0;
  always @(posedge hclk) pin_level <= pin_want;
endmodule

// ==== tb_top.sv ====
// testbench: register map, edge flags, override, force and irq of the aggregator
module tb_top;
  import fpia_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} fpia_row_t;
  logic        hclk, hresetn, hsel, hwrite, hready, irq;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic [5:0]  pin_want, pin_level;
  int          failures, n_tests;
  fpia_row_t   rows [10] = '{
    '{0, 8'h34, 0, 0}, '{0, 8'h38, 0, 0}, '{0, 8'h3c, 0, 0},
    '{0, 8'h30, 0, 32'h00111111}, '{1, 8'h34, 32'hffffffff, 32'h00ffffff},
    '{1, 8'h38, 32'h5a5a5a5a, 32'h005a5a5a}, '{1, 8'h3c, 32'hffffffff, 32'h005b5b5b},
    '{1, 8'h34, 32'hcccccc, 32'hcccccc}, '{1, 8'h38, 0, 0}, '{1, 8'h40, 32'hffffffff, 0}};

  fpia_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hrdata, .hresp, .pin_level, .irq_first_core(irq));
  fpia_pin_model pin_u (.hclk, .pin_want, .pin_level);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= FPIA_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_v = hrdata;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  // two sampling edges plus the model stage, with slack
  task automatic pins(input logic [5:0] p);
    pin_want <= p;
    repeat (6) @(posedge hclk);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    failures++;
    results();
  end
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, pin_want} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
      chk({30'h0, hresp}, {30'h0, FPIA_HRESP_OKAY});
    end
    $display("register rows done");
    pins(6'h01);
    rchk(8'h30, 32'h0011111a);
    rchk(8'h3c, 32'h00000008);
    chk({31'h0, irq}, 32'h1);
    pins(6'h00);
    rchk(8'h30, 32'h0011111d);
    bus(1'b1, 8'h30, 32'h8);
    rchk(8'h30, 32'h00111115);
    bus(1'b1, 8'h30, 32'hf);
    rchk(8'h30, 32'h00111111);
    rchk(8'h3c, 32'h0);
    chk({31'h0, irq}, 32'h0);
    pins(6'h20);
    rchk(8'h30, 32'h00a11111);
    bus(1'b1, 8'h30, 32'h00ffffff);
    $display("edge flag test done");
    // invert on ss makes a rise, forcing low then makes a fall
    bus(1'b1, 8'h58, 32'h4);
    pins(6'h20);
    rchk(8'h30, 32'h002111a1);
    bus(1'b1, 8'h58, 32'h8);
    pins(6'h20);
    rchk(8'h30, 32'h002111d1);
    bus(1'b1, 8'h58, 32'h0);
    rchk(8'h5c, 32'h00002020);
    $display("override test done");
    bus(1'b1, 8'h34, 32'h0);
    bus(1'b1, 8'h38, 32'h00800000);
    rchk(8'h3c, 32'h00800000);
    chk({31'h0, irq}, 32'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(8'h38, 32'h0);
    rchk(8'h34, 32'h0);
    $display("force and reset test done");
    results();
  end
endmodule

bind fpia_top fpia_top_properties chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .irq_first_core);
